// file: design/acp_pkg.sv
// Constants shared by the converter output and configuration port.
package acp_pkg;

    localparam int unsigned DATA_W       = 10;
    localparam int unsigned REG_W        = 8;
    localparam int unsigned FIFO_DEPTH   = 32;

    // Register addresses carried on the two upper data pins.
    localparam logic [1:0]  ADDR_CLAMP_LO = 2'h0;
    localparam logic [1:0]  ADDR_CLAMP_HI = 2'h1;
    localparam logic [1:0]  ADDR_CONTROL  = 2'h2;

    // Reset values.
    localparam logic [7:0]  CLAMP_LO_RST  = 8'h00;
    localparam logic [7:0]  CLAMP_HI_RST  = 8'h00;
    localparam logic [7:0]  CONTROL_RST   = 8'h01;

    // Control register field positions.
    localparam int unsigned GAIN_LSB      = 0;
    localparam int unsigned GAIN_W        = 3;
    localparam int unsigned SLEEP_BIT     = 3;
    localparam int unsigned CLAMP_SRC_BIT = 4;
    localparam int unsigned TWOS_BIT      = 5;
    localparam int unsigned CLAMP_DIS_BIT = 6;
    localparam int unsigned CLAMP_HI_W    = 2;

    // Timing.
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned WAKE_TIME_NS  = 1000;
    localparam int unsigned WAKE_CYCLES   =
        (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAKE_CNT_W    = 4;
    localparam int unsigned PIPE_STAGES   = 3;

endpackage : acp_pkg

// file: design/acp_fifo.sv
// Show-ahead FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module acp_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             ref_clk_i,   // Clock.
    input  wire logic             resetn_i,    // Async reset, low.
    input  wire logic             in_valid_i,  // Write request.
    output logic                  in_ready_o,  // Space available.
    input  wire logic [WIDTH-1:0] in_data_i,   // Write data.
    output logic                  out_valid_o, // Data available.
    input  wire logic             out_ready_i, // Read request.
    output logic [WIDTH-1:0]      out_data_o   // Head word.
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } acp_fifo_state_t;

    acp_fifo_state_t st_reg;
    acp_fifo_state_t st_next;
    logic            push;
    logic            pop;

    assign in_ready_o  = (st_reg.count != DEPTH[AW:0]);
    assign out_valid_o = (st_reg.count != '0);
    assign out_data_o  = st_reg.mem[st_reg.rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.mem[st_reg.wr_ptr] = in_data_i;
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            st_next.count = st_reg.count + 1'b1;
        end
        else if (pop && !push)
        begin
            st_next.count = st_reg.count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end
endmodule : acp_fifo
`default_nettype wire

// file: design/acp_port.sv
// Converter result output and write-only configuration port.
// Notes on behaviour
// - Results drive data pins while enable low.
// - Over-range flag driven with result, released otherwise.
// - Default format is unsigned binary 0..1023.
// - Control bit 5 selects two's complement.
// - Control bit 3 set halts conversions.
// - Clearing bit 3 wakes after wake-up time.
// - Control bit 6 disables clamp only.
// - Enable high releases data and flag drivers.
// - Address 00 loads clamp code low byte.
// - Address 01 loads clamp code top bits.
// - Clamp code is ten bits, 0..1023.
// - Clamp source external pin after power-up.
// - Clamp active only while clamp pin high.
// - Result appears fourth edge after sampling.
// - Address 10 is control; 11 never written.
// - Control bit 4 selects clamp source.
// - Control bits 2:0 gain, default 001.
`timescale 1ns/1ps
`default_nettype none
module acp_port (
    input  wire logic                ref_clk_i,     // Sample clock.
    input  wire logic                resetn_i,      // Async reset, low.
    input  wire logic [9:0]          conv_code_i,   // Core result code.
    input  wire logic                conv_ovr_i,    // Core over-range.
    input  wire logic                conv_valid_i,  // Core result valid.
    output logic                     conv_ready_o,  // Buffer has room.
    input  wire logic                out_en_n_i,    // Output enable pin.
    input  wire logic                wr_strobe_i,   // Write strobe pin.
    input  wire logic                clamp_pin_i,   // Clamp control pin.
    input  wire logic [9:0]          data_pin_i,    // Data pins, in.
    output logic [9:0]               data_pin_o,    // Data pins, out.
    output logic                     data_pin_oe_o, // Data pins drive.
    output logic                     over_range_flag_o,    // Flag out.
    output logic                     over_range_flag_oe_o, // Flag drive.
    output logic                     sleep_control_bit_o,  // Powered down.
    output logic                     conv_enable_o, // Core may convert.
    output logic                     clamp_active_o,       // Clamp on.
    output logic                     clamp_source_select_o, // 1 = DAC.
    output logic [9:0]               clamp_code_o,  // Clamp DAC code.
    output logic [acp_pkg::GAIN_W-1:0] gain_code_o  // Amplifier gain.
);
    import acp_pkg::*;

    typedef struct packed {
        logic [2:0]                     oe_sync;
        logic [2:0]                     wr_sync;
        logic [2:0]                     clamp_sync;
        logic [2:0][DATA_W-1:0]         dq_sync;
        logic                           oe_lvl;
        logic                           wr_lvl;
        logic                           clamp_lvl;
        logic [DATA_W-1:0]              dq_lvl;
        logic [REG_W-1:0]               clamp_lo;
        logic [REG_W-1:0]               clamp_hi;
        logic [REG_W-1:0]               ctrl;
        logic [WAKE_CNT_W-1:0]          wake_cnt;
        logic [PIPE_STAGES-1:0][DATA_W:0] pipe;
        logic [PIPE_STAGES-1:0]         pipe_v;
        logic [DATA_W-1:0]              dq_out;
        logic                           ovr_out;
    } acp_state_t;

    acp_state_t        st_reg;
    acp_state_t        st_next;
    logic              fifo_in_valid;
    logic              fifo_out_valid;
    logic              fifo_pop;
    logic [DATA_W:0]   fifo_head;
    logic              awake;

    // ------------------------------------------------------------------
    // Pin filtering
    // ------------------------------------------------------------------
    // A filtered level changes only when stages two and three agree.
    function automatic logic settle(input logic s2, input logic s3,
                                    input logic old);
        settle = (s2 == s3) ? s3 : old;
    endfunction : settle

    // ------------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------------
    assign awake         = !st_reg.ctrl[SLEEP_BIT] && (st_reg.wake_cnt == '0);
    assign fifo_in_valid = conv_valid_i && awake;
    // Draining pauses while the pins are in write mode, so results
    // queue up instead of being lost and back-pressure reaches the core.
    assign fifo_pop      = fifo_out_valid && !st_reg.oe_lvl;

    acp_fifo #(
        .WIDTH (DATA_W + 1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (conv_ready_o),
        .in_data_i   ({conv_ovr_i, conv_code_i}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_head)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;

        st_next.oe_sync    = {st_reg.oe_sync[1:0], out_en_n_i};
        st_next.wr_sync    = {st_reg.wr_sync[1:0], wr_strobe_i};
        st_next.clamp_sync = {st_reg.clamp_sync[1:0], clamp_pin_i};
        st_next.dq_sync    = {st_reg.dq_sync[1:0], data_pin_i};

        st_next.oe_lvl    = settle(st_reg.oe_sync[1], st_reg.oe_sync[2],
                                   st_reg.oe_lvl);
        st_next.wr_lvl    = settle(st_reg.wr_sync[1], st_reg.wr_sync[2],
                                   st_reg.wr_lvl);
        st_next.clamp_lvl = settle(st_reg.clamp_sync[1],
                                   st_reg.clamp_sync[2], st_reg.clamp_lvl);
        for (int i = 0; i < DATA_W; i++)
        begin
            st_next.dq_lvl[i] = settle(st_reg.dq_sync[1][i],
                                       st_reg.dq_sync[2][i],
                                       st_reg.dq_lvl[i]);
        end

        // Register write on the strobe's falling edge in input mode.
        if (st_reg.wr_lvl && !st_next.wr_lvl && st_reg.oe_lvl)
        begin
            case (st_reg.dq_lvl[9:8])
                ADDR_CLAMP_LO: st_next.clamp_lo = st_reg.dq_lvl[7:0];
                ADDR_CLAMP_HI: st_next.clamp_hi = st_reg.dq_lvl[7:0];
                ADDR_CONTROL:  st_next.ctrl     = st_reg.dq_lvl[7:0];
                default:       st_next.ctrl     = st_reg.ctrl;
            endcase
        end

        // Wake-up delay after leaving power-down.
        if (st_reg.ctrl[SLEEP_BIT])
        begin
            st_next.wake_cnt = WAKE_CYCLES[WAKE_CNT_W-1:0];
        end
        else if (st_reg.wake_cnt != '0)
        begin
            st_next.wake_cnt = st_reg.wake_cnt - 1'b1;
        end

        // Pop, format, then two delay stages and the output register.
        st_next.pipe_v[0] = fifo_pop;
        st_next.pipe[0]   = fifo_head;
        if (st_reg.ctrl[TWOS_BIT])
        begin
            st_next.pipe[0][DATA_W-1] = ~fifo_head[DATA_W-1];
        end
        for (int s = 1; s < PIPE_STAGES; s++)
        begin
            st_next.pipe_v[s] = st_reg.pipe_v[s-1];
            st_next.pipe[s]   = st_reg.pipe[s-1];
        end
        if (st_reg.pipe_v[PIPE_STAGES-1])
        begin
            st_next.dq_out  = st_reg.pipe[PIPE_STAGES-1][DATA_W-1:0];
            st_next.ovr_out = st_reg.pipe[PIPE_STAGES-1][DATA_W];
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_reg          <= '0;
            st_reg.oe_sync  <= 3'h7;
            st_reg.oe_lvl   <= 1'b1;
            st_reg.clamp_lo <= CLAMP_LO_RST;
            st_reg.clamp_hi <= CLAMP_HI_RST;
            st_reg.ctrl     <= CONTROL_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign data_pin_o            = st_reg.dq_out;
    assign data_pin_oe_o         = !st_reg.oe_lvl;
    assign over_range_flag_o     = st_reg.ovr_out;
    assign over_range_flag_oe_o  = !st_reg.oe_lvl;
    assign sleep_control_bit_o   = st_reg.ctrl[SLEEP_BIT];
    assign conv_enable_o         = awake;
    assign clamp_active_o        = st_reg.clamp_lvl &&
                                   !st_reg.ctrl[CLAMP_DIS_BIT];
    assign clamp_source_select_o = st_reg.ctrl[CLAMP_SRC_BIT];
    assign clamp_code_o          = {st_reg.clamp_hi[CLAMP_HI_W-1:0],
                                    st_reg.clamp_lo};
    assign gain_code_o           = st_reg.ctrl[GAIN_LSB +: GAIN_W];
endmodule : acp_port
`default_nettype wire

// file: tb/acp_port_props.sv
// Port assertions for the converter output and configuration port.
`timescale 1ns/1ps
`default_nettype none
module acp_port_props (
    input wire logic       ref_clk_i,            // Clock.
    input wire logic       resetn_i,             // Reset, low.
    input wire logic       out_en_n_i,           // Enable pin.
    input wire logic       wr_strobe_i,          // Strobe pin.
    input wire logic       clamp_pin_i,          // Clamp pin.
    input wire logic       data_pin_oe_o,        // Data drive.
    input wire logic       over_range_flag_oe_o, // Flag drive.
    input wire logic       sleep_control_bit_o,  // Asleep.
    input wire logic       conv_enable_o,        // Awake.
    input wire logic       conv_ready_o,         // Room.
    input wire logic       clamp_active_o,       // Clamp on.
    input wire logic [9:0] clamp_code_o,         // Clamp code.
    input wire logic [2:0] gain_code_o           // Gain.
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    property p_oe_pair; data_pin_oe_o == over_range_flag_oe_o; endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("flag drive differs");
    property p_oe_off; out_en_n_i [*5] |-> !data_pin_oe_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive not released");
    property p_oe_on; !out_en_n_i [*6] |-> data_pin_oe_o; endproperty
    a_oe_on: assert property (p_oe_on) else $error("data not driven");
    property p_clamp; !clamp_pin_i [*5] |-> !clamp_active_o; endproperty
    a_clamp: assert property (p_clamp) else $error("clamp on, pin low");
    property p_sleep; sleep_control_bit_o |-> !conv_enable_o; endproperty
    a_sleep: assert property (p_sleep) else $error("converting asleep");
    property p_wake;
        $fell(sleep_control_bit_o) |-> (!conv_enable_o) [*8] ##[1:6] conv_enable_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up time wrong");
    property p_reg_hold;
        $changed({clamp_code_o, gain_code_o, sleep_control_bit_o})
            |-> !wr_strobe_i && $past(wr_strobe_i, 6);
    endproperty
    a_reg_hold: assert property (p_reg_hold) else $error("update w/o strobe");
    property p_rst_val;
        $rose(resetn_i) |-> gain_code_o == 3'h1 && clamp_code_o == 10'h000;
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("bad reset value");
    c_full: cover property (!conv_ready_o);
    c_wake: cover property ($fell(sleep_control_bit_o));
    c_clamp: cover property (clamp_active_o);
endmodule : acp_port_props
`default_nettype wire

// file: tb/acp_host.sv
// Host model: drives the enable, strobe and shared data pins.
`timescale 1ns/1ps
`default_nettype none
module acp_host (
    input  wire logic       ref_clk_i,  // Clock.
    input  wire logic [9:0] dev_data_i, // Device pin drive.
    input  wire logic       dev_oe_i,   // Device drives pins.
    output logic            out_en_n_o, // Enable pin.
    output logic            wr_strobe_o, // Strobe pin.
    output logic [9:0]      bus_o       // Resolved pin level.
);
    logic       drive = 1'b0;
    logic [9:0] hdata = 10'h000;
    logic [9:0] last  = 10'h000;
    initial out_en_n_o = 1'b1;
    initial wr_strobe_o = 1'b0;
    // A released bus shows the inverse of the last level driven on it.
    always @(posedge ref_clk_i)
    begin
        if (dev_oe_i || drive)
        begin
            last <= bus_o;
        end
    end
    assign bus_o = dev_oe_i ? dev_data_i : drive ? hdata : ~last;
    task automatic write(input logic [1:0] addr, input logic [7:0] val);
        @(negedge ref_clk_i);
        out_en_n_o = 1'b1;
        drive = 1'b1;
        hdata = {addr, val};
        repeat (5) @(negedge ref_clk_i);
        wr_strobe_o = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        wr_strobe_o = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        drive = 1'b0;
    endtask : write
    task automatic enable_out;
        @(negedge ref_clk_i);
        drive = 1'b0;
        @(negedge ref_clk_i);
        out_en_n_o = 1'b0;
        repeat (6) @(negedge ref_clk_i);
    endtask : enable_out
endmodule : acp_host
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the converter port.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acp_pkg::*;
    logic ref_clk_i = 0, resetn_i = 0, conv_valid_i = 0, conv_ovr_i = 0;
    logic clamp_pin_i = 0, twos = 0;
    logic [9:0] conv_code_i = 0, data_pin_i, data_pin_o, clamp_code_o;
    logic [2:0] gain_code_o;
    logic conv_ready_o, out_en_n_i, wr_strobe_i, data_pin_oe_o, flag, flag_oe;
    logic sleep_o, conv_en, clamp_act, clamp_src;
    logic [10:0] exp_q[$];
    logic [10:0] last_exp = 0, prev_out = 0;
    int err_count = 0, checks = 0, cycles = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    acp_port dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .conv_code_i(conv_code_i), .conv_ovr_i(conv_ovr_i),
        .conv_valid_i(conv_valid_i), .conv_ready_o(conv_ready_o),
        .out_en_n_i(out_en_n_i), .wr_strobe_i(wr_strobe_i),
        .clamp_pin_i(clamp_pin_i), .data_pin_i(data_pin_i),
        .data_pin_o(data_pin_o), .data_pin_oe_o(data_pin_oe_o),
        .over_range_flag_o(flag), .over_range_flag_oe_o(flag_oe),
        .sleep_control_bit_o(sleep_o), .conv_enable_o(conv_en),
        .clamp_active_o(clamp_act), .clamp_source_select_o(clamp_src),
        .clamp_code_o(clamp_code_o), .gain_code_o(gain_code_o));
    acp_host u_host (.ref_clk_i(ref_clk_i), .dev_data_i(data_pin_o),
        .dev_oe_i(data_pin_oe_o), .out_en_n_o(out_en_n_i),
        .wr_strobe_o(wr_strobe_i), .bus_o(data_pin_i));
    task automatic check(input logic [15:0] seen, input logic [15:0] ex);
        checks++;
        if (seen !== ex)
        begin
            $display("BAD %0t seen %h expected %h", $time, seen, ex);
            err_count++;
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d, err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    // Each result is made to differ from the one before it.
    task automatic send(input int n);
        logic [10:0] v;
        logic [10:0] e;
        repeat (n)
        begin
            v = 11'($urandom);
            e = {v[10], v[9] ^ twos, v[8:0]};
            if (e === last_exp)
            begin
                v[0] = !v[0];
                e[0] = !e[0];
            end
            @(negedge ref_clk_i);
            {conv_valid_i, conv_ovr_i, conv_code_i} = {1'b1, v};
            while (!(conv_ready_o && conv_en)) @(negedge ref_clk_i);
            @(posedge ref_clk_i);
            exp_q.push_back(e);
            last_exp = e;
        end
        @(negedge ref_clk_i) conv_valid_i = 0;
    endtask : send
    task automatic drain;
        for (int i = 0; i < 100 && exp_q.size() != 0; i++) @(negedge ref_clk_i);
        check(11'(exp_q.size()), 11'h000);
    endtask : drain
    always @(posedge ref_clk_i)
    begin
        #1;
        if (resetn_i && {flag, data_pin_o} !== prev_out)
        begin
            prev_out = {flag, data_pin_o};
            if (exp_q.size() == 0) check(prev_out, ~prev_out);
            else check(prev_out, exp_q.pop_front());
        end
    end
    always @(posedge ref_clk_i)
        if (++cycles == 8000)
        begin
            err_count++;
            finish_test();
        end
    initial
    begin
        void'($urandom(32'h18AC137A));
        repeat (5) @(negedge ref_clk_i);
        resetn_i = 1;
        repeat (4) @(negedge ref_clk_i);
        check(gain_code_o, CONTROL_RST[2:0]);
        check({clamp_src, clamp_code_o}, 11'h000);
        check({sleep_o, data_pin_oe_o}, 11'h000);
        u_host.enable_out();
        check({data_pin_oe_o, flag_oe}, 11'h003);
        send(1);
        repeat (3) @(posedge ref_clk_i);
        #2 check(11'(exp_q.size()), 11'h001);
        @(posedge ref_clk_i);
        #2 check(11'(exp_q.size()), 11'h000);
        send(12);
        drain();
        u_host.write(ADDR_CONTROL, 8'h21);
        check({data_pin_oe_o, flag_oe}, 11'h000);
        twos = 1;
        u_host.enable_out();
        send(8);
        drain();
        u_host.write(ADDR_CLAMP_LO, 8'h0F);
        u_host.write(ADDR_CLAMP_HI, 8'h01);
        check(clamp_code_o, 10'h10F);
        u_host.write(ADDR_CLAMP_LO, 8'hFF);
        u_host.write(ADDR_CLAMP_HI, 8'hFF);
        check(clamp_code_o, 10'h3FF);
        u_host.write(2'h3, 8'h00);
        check({clamp_code_o, gain_code_o}, 13'h1FF9);
        clamp_pin_i = 1;
        for (int g = 0; g < 8; g++)
        begin
            u_host.write(ADDR_CONTROL, 8'h50 | 8'(g));
            check({clamp_src, clamp_act, gain_code_o}, 11'(8 * 2 + g));
        end
        u_host.write(ADDR_CONTROL, 8'h10 | 8'($urandom_range(7)));
        check(clamp_act, 1'b1);
        @(negedge ref_clk_i) clamp_pin_i = 0;
        repeat (6) @(negedge ref_clk_i);
        check(clamp_act, 1'b0);
        u_host.write(ADDR_CONTROL, 8'h09);
        check({sleep_o, conv_en}, 11'h002);
        u_host.write(ADDR_CONTROL, 8'h01);
        check({sleep_o, conv_en}, 11'h000);
        repeat (8) @(negedge ref_clk_i);
        check(conv_en, 1'b1);
        twos = 0;
        send(FIFO_DEPTH);
        check(conv_ready_o, 1'b0);
        u_host.enable_out();
        drain();
        finish_test();
    end
endmodule : tb
bind acp_port acp_port_props u_props (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .out_en_n_i(out_en_n_i), .wr_strobe_i(wr_strobe_i),
    .clamp_pin_i(clamp_pin_i), .data_pin_oe_o(data_pin_oe_o),
    .over_range_flag_oe_o(over_range_flag_oe_o),
    .sleep_control_bit_o(sleep_control_bit_o), .conv_enable_o(conv_enable_o),
    .conv_ready_o(conv_ready_o), .clamp_active_o(clamp_active_o),
    .clamp_code_o(clamp_code_o), .gain_code_o(gain_code_o));
`default_nettype wire
